/* rtl/dma_hs_pkg.sv */
package dma_hs_pkg;

  localparam int unsigned CHANNELS   = 2;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned MSEL_W     = 4;
  localparam int unsigned WAIT_W     = 3;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CHAN_W     = 1;

  // mode encodings of the per-channel mode input
  typedef enum logic [1:0] {
    MODE_OFF      = 2'h0,
    MODE_HANDSHK  = 2'h1,
    MODE_EXT_HS   = 2'h2,
    MODE_PACED    = 2'h3
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_WAIT   = 3'h2,
    ST_HOLD   = 3'h3,
    ST_END    = 3'h4,
    ST_GAP    = 3'h5
  } state_t;

  // one word crossing the fifo: channel, direction and data
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic              write;
    logic [DATA_W-1:0] data;
  } xfer_t;

  // external memory bus, driven as bus master
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd_n;
    logic              wr_n;
    logic              sync_write_select_n;
    logic              page;
    logic [MSEL_W-1:0] memory_select_n;
  } bus_t;

  localparam logic [CHAN_W-1:0] CHAN_RESET  = 1'h0;
  localparam logic [WAIT_W-1:0] WAIT_RESET  = 3'h0;
  localparam logic [1:0]        GAP_CYCLES  = 2'h1;

endpackage

/* rtl/word_fifo.sv */
`timescale 1ns/10ps
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,      // system clock
  input  wire logic             rst_b,    // async reset, active low
  input  wire logic             ce,       // clock enable
  input  wire logic             in_valid, // write request
  output logic                  in_ready, // space available
  input  wire logic [WIDTH-1:0] in_data,  // write data
  output logic                  out_valid,// data available
  input  wire logic             out_ready,// read accept
  output logic [WIDTH-1:0]      out_data  // head word
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      if (pop)
      begin
        rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      end
      count_reg <= (AW+1)'(count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

endmodule

/* rtl/dma_handshake_port.sv */
// Behaviour
// - handshake mode: grant strobe alone latches or enables external data
// - external handshake: address, strobes, page, selects, ack and grant together
// - paced master: address, strobes, page, selects, ack only; grant never asserted
// - paced master transfers run as ordinary bus-master read or write cycles
// - requests sampled on input clock; late edges recognised one cycle later
// - request held low during a write holds off its completion
// - request held low on a read extends data-valid window per cycle
// - grant low phase lengthened by one clock per programmed wait state
// - hold or idle cycle adds one clock after grant rises
// - external handshake read: read strobe low no later than grant, rises one clock before grant
// - external handshake write: write strobe rises before grant, address held
`timescale 1ns/10ps
module dma_handshake_port (
  input  wire logic                                    clk,          // input clock, 10 MHz
  input  wire logic                                    rst_b,        // async reset, active low
  input  wire logic                                    ce,           // clock enable
  input  wire logic [dma_hs_pkg::CHANNELS-1:0]         dma_request_n,// request pins, async
  output logic      [dma_hs_pkg::CHANNELS-1:0]         dma_grant_n,  // grant strobes
  input  wire dma_hs_pkg::mode_t [dma_hs_pkg::CHANNELS-1:0] chan_mode,// per-channel mode
  input  wire logic [dma_hs_pkg::CHANNELS-1:0]         chan_write,   // 1 = memory write
  input  wire logic [dma_hs_pkg::ADDR_W-1:0]           chan_addr,    // target address
  input  wire logic [dma_hs_pkg::MSEL_W-1:0]           chan_msel_n,  // memory selects to use
  input  wire logic                                    chan_sync,    // synchronous cycle
  input  wire logic [dma_hs_pkg::WAIT_W-1:0]           wait_states,  // programmed waits
  input  wire logic                                    hold_idle_en, // hold or idle cycle
  input  wire logic                                    ack_in,       // slave acknowledge
  input  wire logic [dma_hs_pkg::DATA_W-1:0]           data_in,      // read data bus
  output dma_hs_pkg::bus_t                             bus_out,      // master bus outputs
  output logic      [dma_hs_pkg::DATA_W-1:0]           data_out,     // write data bus
  output logic                                         data_oe,      // write data enable
  output logic                                         rd_valid,     // fifo word available
  input  wire logic                                    rd_ready,     // user accepts word
  output dma_hs_pkg::xfer_t                            rd_word,      // captured read word
  input  wire logic                                    wr_valid,     // user write word valid
  output logic                                         wr_ready,     // write word taken
  input  wire logic [dma_hs_pkg::DATA_W-1:0]           wr_data       // user write data
);

  localparam int unsigned N = dma_hs_pkg::CHANNELS;

  logic [N-1:0] req_meta_reg;
  logic [N-1:0] req_sync_reg;
  dma_hs_pkg::state_t state_reg;
  logic [dma_hs_pkg::CHAN_W-1:0] chan_reg;
  logic [dma_hs_pkg::WAIT_W-1:0] wait_cnt_reg;
  logic                          write_reg;
  logic                          grant_mode_reg;
  logic                          fifo_in_ready;
  logic                          cap_valid;
  dma_hs_pkg::xfer_t             cap_word;
  logic                          pick_ok;
  logic [dma_hs_pkg::CHAN_W-1:0] pick_chan;

  // lowest numbered live request wins
  function automatic logic [dma_hs_pkg::CHAN_W-1:0] first_req(input logic [N-1:0] r);
    logic [dma_hs_pkg::CHAN_W-1:0] c;
    c = dma_hs_pkg::CHAN_RESET;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (r[i])
      begin
        c = dma_hs_pkg::CHAN_W'(i);
      end
    end
    return c;
  endfunction

  function automatic logic mode_on(input dma_hs_pkg::mode_t m);
    return m != dma_hs_pkg::MODE_OFF;
  endfunction

  logic [N-1:0] live_req;
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      live_req[i] = !req_sync_reg[i] && mode_on(chan_mode[i]);
    end
  end

  // a write only starts when a data word is on hand; a read needs fifo room
  assign pick_chan = first_req(live_req);
  assign pick_ok   = (live_req != '0) &&
                     (chan_write[pick_chan] ? wr_valid : fifo_in_ready);

  // two flops: the pin is asynchronous, so late edges land a cycle later
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_meta_reg <= '1;
      req_sync_reg <= '1;
    end
    else if (ce)
    begin
      req_meta_reg <= dma_request_n;
      req_sync_reg <= req_meta_reg;
    end
  end

  logic held_low;
  assign held_low = !req_sync_reg[chan_reg];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg      <= dma_hs_pkg::ST_IDLE;
      chan_reg       <= dma_hs_pkg::CHAN_RESET;
      wait_cnt_reg   <= dma_hs_pkg::WAIT_RESET;
      write_reg      <= 1'b0;
      grant_mode_reg <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_reg)
        dma_hs_pkg::ST_IDLE:
        begin
          if (pick_ok)
          begin
            chan_reg       <= pick_chan;
            write_reg      <= chan_write[pick_chan];
            grant_mode_reg <= chan_mode[pick_chan] != dma_hs_pkg::MODE_PACED;
            wait_cnt_reg   <= wait_states;
            state_reg      <= dma_hs_pkg::ST_SETUP;
          end
        end
        dma_hs_pkg::ST_SETUP:
        begin
          state_reg <= dma_hs_pkg::ST_WAIT;
        end
        dma_hs_pkg::ST_WAIT:
        begin
          if (wait_cnt_reg != '0)
          begin
            wait_cnt_reg <= wait_cnt_reg - 1'b1;
          end
          else if (ack_in)
          begin
            state_reg <= dma_hs_pkg::ST_HOLD;
          end
        end
        dma_hs_pkg::ST_HOLD:
        begin
          // request still low stretches the access one clock at a time
          if (!(grant_mode_reg && held_low))
          begin
            state_reg <= dma_hs_pkg::ST_END;
          end
        end
        dma_hs_pkg::ST_END:
        begin
          state_reg <= hold_idle_en ? dma_hs_pkg::ST_GAP : dma_hs_pkg::ST_IDLE;
        end
        dma_hs_pkg::ST_GAP:
        begin
          state_reg <= dma_hs_pkg::ST_IDLE;
        end
        default:
        begin
          state_reg <= dma_hs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  logic active;
  logic strobe_on;
  assign active    = (state_reg == dma_hs_pkg::ST_SETUP) || (state_reg == dma_hs_pkg::ST_WAIT) ||
                     (state_reg == dma_hs_pkg::ST_HOLD)  || (state_reg == dma_hs_pkg::ST_END);
  // strobes cover setup..hold; the END cycle has grant low but rd/wr already high
  assign strobe_on = active && (state_reg != dma_hs_pkg::ST_END);

  logic ext_mode;
  assign ext_mode = chan_mode[chan_reg] != dma_hs_pkg::MODE_HANDSHK;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dma_grant_n <= '1;
      bus_out     <= '{addr: '0, rd_n: 1'b1, wr_n: 1'b1, sync_write_select_n: 1'b1,
                       page: 1'b0, memory_select_n: '1};
      data_out    <= '0;
      data_oe     <= 1'b0;
    end
    else if (ce)
    begin
      for (int i = 0; i < N; i++)
      begin
        dma_grant_n[i] <= !(pick_ok && state_reg == dma_hs_pkg::ST_IDLE &&
                            pick_chan == dma_hs_pkg::CHAN_W'(i) &&
                            chan_mode[i] != dma_hs_pkg::MODE_PACED) &&
                          !(grant_mode_reg && chan_reg == dma_hs_pkg::CHAN_W'(i) &&
                            (state_reg == dma_hs_pkg::ST_SETUP ||
                             state_reg == dma_hs_pkg::ST_WAIT ||
                             (state_reg == dma_hs_pkg::ST_HOLD)));
      end
      if (state_reg == dma_hs_pkg::ST_IDLE && pick_ok &&
          chan_mode[pick_chan] != dma_hs_pkg::MODE_HANDSHK)
      begin
        bus_out.addr            <= chan_addr;
        bus_out.memory_select_n <= chan_msel_n;
        bus_out.page            <= 1'b0;
        bus_out.sync_write_select_n <= !(chan_sync && chan_write[pick_chan]);
        bus_out.rd_n            <= chan_write[pick_chan];
        bus_out.wr_n            <= !chan_write[pick_chan];
      end
      else if (state_reg == dma_hs_pkg::ST_HOLD && !(grant_mode_reg && held_low))
      begin
        bus_out.rd_n <= 1'b1;
        bus_out.wr_n <= 1'b1;
        bus_out.sync_write_select_n <= 1'b1;
      end
      else if (state_reg == dma_hs_pkg::ST_END)
      begin
        bus_out.memory_select_n <= '1;
      end
      if (state_reg == dma_hs_pkg::ST_IDLE && pick_ok && chan_write[pick_chan])
      begin
        data_out <= wr_data;
        data_oe  <= 1'b1;
      end
      else if (state_reg == dma_hs_pkg::ST_END)
      begin
        data_oe <= 1'b0;
      end
    end
  end

  assign wr_ready  = ce && state_reg == dma_hs_pkg::ST_IDLE && pick_ok && chan_write[pick_chan];
  assign cap_valid = ce && state_reg == dma_hs_pkg::ST_HOLD && !write_reg &&
                     !(grant_mode_reg && held_low);
  assign cap_word  = '{chan: chan_reg, write: 1'b0, data: data_in};

  word_fifo #(
    .WIDTH ($bits(dma_hs_pkg::xfer_t)),
    .DEPTH (dma_hs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (cap_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_word),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_word)
  );

  // paced transfers never touch a grant line
  chk_paced_no_grant: assert property (@(posedge clk) disable iff (!rst_b)
    (active && !grant_mode_reg) |-> (dma_grant_n == '1))
    else $error("grant asserted in paced master transfer");

  chk_grant_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == dma_hs_pkg::ST_IDLE || state_reg == dma_hs_pkg::ST_GAP) |-> (dma_grant_n == '1))
    else $error("grant low outside a transfer");

  chk_wait_len: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && state_reg == dma_hs_pkg::ST_WAIT && grant_mode_reg) |=> !dma_grant_n[chan_reg])
    else $error("grant released during wait phase");

  chk_hold_write: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && state_reg == dma_hs_pkg::ST_HOLD && grant_mode_reg && held_low)
    |=> (state_reg == dma_hs_pkg::ST_HOLD))
    else $error("access completed while request held low");

  chk_gap_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && state_reg == dma_hs_pkg::ST_END && hold_idle_en) |=> (state_reg == dma_hs_pkg::ST_GAP))
    else $error("missing hold or idle cycle");

  chk_no_gap: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && state_reg == dma_hs_pkg::ST_END && !hold_idle_en) |=> (state_reg == dma_hs_pkg::ST_IDLE))
    else $error("unexpected idle cycle");

  chk_wr_before_grant: assert property (@(posedge clk) disable iff (!rst_b)
    (active && !strobe_on) |-> bus_out.wr_n && bus_out.rd_n)
    else $error("strobe still low at grant release");

  chk_rd_with_grant: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == dma_hs_pkg::ST_WAIT && grant_mode_reg && ext_mode && !write_reg)
    |-> !bus_out.rd_n)
    else $error("read strobe not low with grant");

endmodule

/* testbench/dma_requester.sv */
`timescale 1ns/10ps
module dma_requester (
  input  wire logic       clk,           // input clock
  input  wire logic       rst_b,         // async reset, active low
  input  wire logic [1:0] go,            // start a request per channel
  input  wire logic [1:0] served,        // grant or paced strobe seen
  input  wire logic [3:0] extra,         // cycles to keep request low after service
  output logic      [1:0] dma_request_n  // request pins, pulled up when idle
);
  logic [1:0] busy_reg;
  logic [3:0] cnt_reg [2];

  assign dma_request_n = ~busy_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_reg <= 2'h0;
      cnt_reg  <= '{4'h0, 4'h0};
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (go[i])
        begin
          busy_reg[i] <= 1'b1;
          cnt_reg[i]  <= 4'h0;
        end
        // staying low past service is how the peripheral stretches the access
        else if (busy_reg[i] && (served[i] || cnt_reg[i] != 4'h0))
        begin
          if (cnt_reg[i] == extra)
            busy_reg[i] <= 1'b0;
          else
            cnt_reg[i] <= cnt_reg[i] + 4'h1;
        end
      end
    end
  end
endmodule

/* testbench/dma_handshake_port_tb_top.sv */
`timescale 1ns/10ps
module dma_handshake_port_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, ack_in = 1'b1, chan_sync = 1'b0;
  logic hold_idle_en = 1'b0, rd_ready = 1'b0, wr_valid = 1'b1, paced = 1'b0;
  logic [1:0] chan_write = 2'h0, go = 2'h0, served, dma_request_n, dma_grant_n;
  logic [31:0] chan_addr = 32'h00001A40, data_in = 32'hC3A50F96;
  logic [31:0] wr_data = 32'h5A5A00FF, data_out, addr_last;
  logic [3:0] chan_msel_n = 4'hE, extra = 4'h0;
  logic [3:0] sel_last;
  logic [2:0] wait_states = 3'h0;
  logic data_oe, rd_valid, wr_ready, firstok;
  dma_hs_pkg::mode_t [1:0] chan_mode;
  dma_hs_pkg::bus_t        bus_out;
  dma_hs_pkg::xfer_t       rd_word;
  int fails = 0, compares = 0, glen, slen, rise0, fall1, g;

  always #50 clk = ~clk;
  // paced transfers never grant, so the bus strobe tells the peripheral it was served
  assign served = ~dma_grant_n | {2{paced & ~(bus_out.rd_n & bus_out.wr_n)}};

  dma_requester peer (.clk(clk), .rst_b(rst_b), .go(go), .served(served), .extra(extra),
    .dma_request_n(dma_request_n));

  dma_handshake_port dut (.clk(clk), .rst_b(rst_b), .ce(ce), .dma_request_n(dma_request_n),
    .dma_grant_n(dma_grant_n), .chan_mode(chan_mode), .chan_write(chan_write),
    .chan_addr(chan_addr), .chan_msel_n(chan_msel_n), .chan_sync(chan_sync),
    .wait_states(wait_states), .hold_idle_en(hold_idle_en), .ack_in(ack_in),
    .data_in(data_in), .bus_out(bus_out), .data_out(data_out), .data_oe(data_oe),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_word(rd_word), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data));

  task automatic cmp_int(input int got, input int exp, input string msg);
    compares++;
    if (got != exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
    end
  endtask

  task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one request per channel in mask; grant and strobe of channel 0 are measured
  task automatic xfer(input dma_hs_pkg::mode_t m, input logic wr, input logic [2:0] w,
                      input logic [3:0] x, input logic [1:0] mask);
    logic st;
    @(posedge clk);
    chan_mode[0] <= mask[0] ? m : dma_hs_pkg::MODE_OFF;
    chan_mode[1] <= mask[1] ? m : dma_hs_pkg::MODE_OFF;
    chan_write   <= {2{wr}};
    wait_states  <= w;
    extra        <= x;
    paced        <= (m == dma_hs_pkg::MODE_PACED);
    go           <= mask;
    @(posedge clk);
    go <= 2'h0;
    glen = 0;
    slen = 0;
    rise0 = -1;
    fall1 = -1;
    firstok = 1'b0;
    for (int i = 0; i < 60; i++)
    begin
      @(negedge clk);
      st = wr ? bus_out.wr_n : bus_out.rd_n;
      if (dma_grant_n[0] === 1'b0)
      begin
        if (glen == 0)
          firstok = (st === 1'b0);
        glen++;
        addr_last = bus_out.addr;
      end
      else if (glen > 0 && rise0 < 0)
        rise0 = i;
      if (st === 1'b0)
      begin
        slen++;
        sel_last = bus_out.memory_select_n;
      end
      if (dma_grant_n[1] === 1'b0 && fall1 < 0)
        fall1 = i;
    end
  endtask

  task automatic t_handshake;
    // no zero-wait baseline: the synchroniser lag would stretch hold there
    xfer(dma_hs_pkg::MODE_HANDSHK, 1'b0, 3'h1, 4'h0, 2'h1);
    g = glen;
    cmp_int(g > 0, 1, "grant in handshake mode");
    xfer(dma_hs_pkg::MODE_HANDSHK, 1'b0, 3'h4, 4'h0, 2'h1);
    cmp_int(glen - g, 3, "wait stretch");
    xfer(dma_hs_pkg::MODE_OFF, 1'b0, 3'h0, 4'h0, 2'h1);
    cmp_int(glen, 0, "grant on idle channel");
    // the request left pending above is served once the channel is enabled
    xfer(dma_hs_pkg::MODE_HANDSHK, 1'b0, 3'h1, 4'h0, 2'h1);
    cmp_int(glen > 0, 1, "pending request granted");
  endtask

  task automatic t_ext_read;
    @(posedge clk);
    rd_ready <= 1'b0;
    data_in  <= 32'h3C5AF069;
    xfer(dma_hs_pkg::MODE_EXT_HS, 1'b0, 3'h2, 4'h0, 2'h1);
    cmp_int(firstok, 1, "read strobe with grant");
    cmp_int(slen, glen - 1, "read strobe window");
    cmp_vec(addr_last, chan_addr, "address during grant");
    cmp_vec(rd_valid, 1'b1, "read word ready");
    cmp_vec(rd_word.data, 32'h3C5AF069, "read word data");
    cmp_vec(rd_word.chan, 1'b0, "read word channel");
    @(posedge clk);
    rd_ready <= 1'b1;
  endtask

  task automatic t_ext_write;
    xfer(dma_hs_pkg::MODE_EXT_HS, 1'b1, 3'h1, 4'h0, 2'h1);
    cmp_int(firstok, 1, "write strobe with grant");
    cmp_int(slen, glen - 1, "write strobe released first");
    cmp_vec(addr_last, chan_addr, "address held to grant rise");
    cmp_vec(data_out, 32'h5A5A00FF, "write data driven");
    cmp_vec(data_oe, 1'b0, "write data released");
  endtask

  task automatic t_extend;
    xfer(dma_hs_pkg::MODE_EXT_HS, 1'b0, 3'h0, 4'h6, 2'h1);
    g = glen;
    xfer(dma_hs_pkg::MODE_EXT_HS, 1'b0, 3'h0, 4'h9, 2'h1);
    cmp_int(glen - g, 3, "read prolonged");
    xfer(dma_hs_pkg::MODE_EXT_HS, 1'b1, 3'h0, 4'h6, 2'h1);
    g = glen;
    xfer(dma_hs_pkg::MODE_EXT_HS, 1'b1, 3'h0, 4'h8, 2'h1);
    cmp_int(glen - g, 2, "write held off");
  endtask

  task automatic t_paced;
    for (int w = 0; w < 2; w++)
    begin
      chan_sync <= w[0];
      xfer(dma_hs_pkg::MODE_PACED, w[0], 3'h0, 4'h0, 2'h1);
      cmp_int(glen, 0, "no grant when paced");
      cmp_int(slen > 0, 1, "paced bus cycle");
      cmp_vec(sel_last, 4'hE, "paced memory selects");
    end
    chan_sync <= 1'b0;
  endtask

  task automatic t_gap;
    xfer(dma_hs_pkg::MODE_HANDSHK, 1'b0, 3'h0, 4'h0, 2'h3);
    g = fall1 - rise0;
    hold_idle_en <= 1'b1;
    xfer(dma_hs_pkg::MODE_HANDSHK, 1'b0, 3'h0, 4'h0, 2'h3);
    cmp_int(fall1 - rise0 - g, 1, "idle cycle after grant");
    hold_idle_en <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    chan_mode[0] = dma_hs_pkg::MODE_OFF;
    chan_mode[1] = dma_hs_pkg::MODE_OFF;
    repeat (12) @(posedge clk);
    rst_b    <= 1'b1;
    rd_ready <= 1'b1;
    @(negedge clk);
    cmp_vec(dma_grant_n, 2'h3, "grant idle after reset");
    t_handshake;
    t_ext_read;
    t_ext_write;
    t_extend;
    t_paced;
    t_gap;
    wrap_up;
  end

  // whole sequence is about 900 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule
